// ==== elt_apb_regs.sv ====
/*
  APB slave holding control, period and pulse-width registers.
  Zero wait states; unmapped addresses read zero and raise pslverr.
  Assumes the core reports its count and state and may clear enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "elt_regs.svh"

module elt_apb_regs
  import elt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Core side
  input  wire logic        en_clear,
  input  wire logic [7:0]  count,
  input  wire logic        drive,
  input  wire logic [1:0]  state,
  output var elt_cfg_t     cfg
);
  elt_cfg_t    cfg_r, cfg_nxt;
  logic [31:0] rd_nxt;
  logic        err_nxt;
  logic        wr;

  assign wr = psel & penable & pwrite;

  // Decode write and read; software set of enable beats a same-cycle clear
  always_comb begin
    cfg_nxt = cfg_r;
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (en_clear) begin
      cfg_nxt.en = 1'b0;
    end
    unique case (paddr)
      `ELT_CTRL_OFS: begin
        rd_nxt = {19'h0, cfg_r.mode, 7'h0, cfg_r.en};
        if (wr) begin
          cfg_nxt.en   = pwdata[`ELT_CTRL_EN_BIT];
          cfg_nxt.mode = pwdata[`ELT_CTRL_MODE_MSB:`ELT_CTRL_MODE_LSB];
        end
      end
      `ELT_PERIOD_OFS: begin
        rd_nxt = {24'h0, cfg_r.period_value};
        if (wr) begin
          cfg_nxt.period_value = pwdata[7:0];
        end
      end
      `ELT_WIDTH_OFS: begin
        rd_nxt = {24'h0, cfg_r.pulse_width_value};
        if (wr) begin
          cfg_nxt.pulse_width_value = pwdata[7:0];
        end
      end
      `ELT_COUNT_OFS:  rd_nxt = {24'h0, count};
      `ELT_STATUS_OFS: rd_nxt = {29'h0, drive, state};
      default:         err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '{en: 1'b0, mode: `ELT_MODE_RST, period_value: `ELT_PERIOD_RST,
                 pulse_width_value: `ELT_WIDTH_RST};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg     = cfg_r;
  // Valid from the setup cycle, where the top level registers the answer
  assign prdata  = (psel & ~pwrite) ? rd_nxt : 32'h0000_0000;
  assign pslverr = psel & err_nxt;
endmodule // elt_apb_regs

`default_nettype wire

// ==== elt_edge_det.sv ====
/*
  Edge qualifier for the external trigger: one-cycle pulse on the edge
  selected by the mode code.
  Assumes the trigger input is already synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "elt_regs.svh"

module elt_edge_det
  import elt_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Trigger and selection
  input  wire logic       trig_in,
  input  wire logic [4:0] mode,
  // Qualified edge
  output logic            edge_pulse
);
  logic trig_r;
  logic trig_nxt;

  // Previous trigger level
  always_comb begin
    trig_nxt = trig_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // Polarity chosen by mode; other codes give no edge
  always_comb begin
    unique case (mode)
      `ELT_MODE_RISE: edge_pulse = trig_in & ~trig_r;
      `ELT_MODE_FALL: edge_pulse = ~trig_in & trig_r;
      default:        edge_pulse = 1'b0;
    endcase
  end
endmodule // elt_edge_det

`default_nettype wire

// ==== elt_oneshot_timer.sv ====
/*
  Edge-triggered hardware-limit one-shot timer with pulse drive output.
  Assumes an APB master on pclk and a trigger synchronous to pclk.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
// How it works
// - Enabled timer waits idle for first edge
// - Later edges reset; resume two clocks after
// - Mode 01100 rising, 01101 falling edges
// - Period match resets counter, clears enable
// - Edges ignored while enable is clear
// - Drive turns on at start and reset edges
// - Drive off at pulse-width match until next reset edge
`timescale 1ns/1ps
`default_nettype none
`include "elt_regs.svh"

module elt_oneshot_timer
  import elt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External trigger and drive
  input  wire logic        trig_in,
  output logic             pwm_drive,
  output logic             running
);
  // =====================================================================
  // Registers and edge detection
  // =====================================================================
  elt_cfg_t    cfg;
  logic        edge_pulse;
  logic [31:0] rdata_w;
  logic        err_w;

  elt_state_t  state_r, state_nxt;
  logic [7:0]  count_r, count_nxt;
  logic [1:0]  hold_r, hold_nxt;
  logic        drive_r, drive_nxt;
  logic        en_clear;

  elt_apb_regs u_regs (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (rdata_w),
    .pslverr  (err_w),
    .en_clear (en_clear),
    .count    (count_r),
    .drive    (drive_r),
    .state    (state_r),
    .cfg      (cfg)
  );

  elt_edge_det u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig_in    (trig_in),
    .mode       (cfg.mode),
    .edge_pulse (edge_pulse)
  );

  // =====================================================================
  // Timer state machine
  // =====================================================================
  // Edge checked before period match: a reset edge in the match cycle
  // still restarts, since only a match without an edge or a cleared enable ends the shot
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    hold_nxt  = hold_r;
    drive_nxt = drive_r;
    en_clear  = 1'b0;
    unique case (state_r)
      ELT_IDLE: begin
        count_nxt = 8'h00;
        drive_nxt = 1'b0;
        if (cfg.en) begin
          state_nxt = ELT_ARMED;
        end
      end
      ELT_ARMED: begin
        if (!cfg.en) begin
          state_nxt = ELT_IDLE;
        end else if (edge_pulse) begin
          state_nxt = ELT_RUN;
          count_nxt = 8'h01;
          drive_nxt = 1'b1;
        end
      end
      ELT_HOLD, ELT_RUN: begin
        if (!cfg.en) begin
          state_nxt = ELT_IDLE;
          count_nxt = 8'h00;
          drive_nxt = 1'b0;
        end else if (edge_pulse) begin
          state_nxt = ELT_HOLD;
          count_nxt = 8'h00;
          hold_nxt  = `ELT_RESUME_CLKS - 2'h1;
          drive_nxt = 1'b1;
        end else if (state_r == ELT_HOLD) begin
          if (hold_r == 2'h0) begin
            state_nxt = ELT_RUN;
            count_nxt = 8'h01;
          end else begin
            hold_nxt = hold_r - 2'h1;
          end
        end else if (count_r == cfg.period_value) begin
          state_nxt = ELT_IDLE;
          count_nxt = 8'h00;
          drive_nxt = 1'b0;
          en_clear  = 1'b1;
        end else begin
          count_nxt = count_r + 8'h01;
          if (count_r == cfg.pulse_width_value) begin
            drive_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ELT_IDLE;
      count_r   <= 8'h00;
      hold_r    <= 2'h0;
      drive_r   <= 1'b0;
      pwm_drive <= 1'b0;
      running   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      count_r   <= count_nxt;
      hold_r    <= hold_nxt;
      drive_r   <= drive_nxt;
      pwm_drive <= drive_nxt;
      running   <= (state_nxt == ELT_RUN) || (state_nxt == ELT_HOLD);
    end
  end

  // Zero wait state answer, registered outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      prdata  <= (psel & ~penable) ? rdata_w : prdata;
      pslverr <= psel & ~penable & err_w;
      pready  <= psel & ~penable;
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  chk_start_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_ARMED && cfg.en && edge_pulse) |=> (drive_r && state_r == ELT_RUN))
    else $error("start edge did not start timer with drive on");
  chk_resume_two: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_RUN && cfg.en && edge_pulse) ##1 !edge_pulse[*2] |=> (count_r == 8'h01))
    else $error("count did not resume two clocks after reset edge");
  chk_period_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_RUN && cfg.en && !edge_pulse && count_r == cfg.period_value)
    |=> (state_r == ELT_IDLE && count_r == 8'h00 && !cfg.en))
    else $error("period match did not stop timer");
  chk_width_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_RUN && cfg.en && !edge_pulse && count_r == cfg.pulse_width_value
     && count_r != cfg.period_value) |=> !drive_r)
    else $error("drive still on after pulse-width match");
  chk_idle_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_IDLE) |=> (count_r == 8'h00 && state_r != ELT_RUN))
    else $error("edge acted while disabled");
  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_RUN && cfg.en && !edge_pulse && count_r != cfg.period_value)
    |=> count_r == $past(count_r) + 8'h01)
    else $error("counter did not advance by one");
  chk_armed_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ELT_ARMED && !edge_pulse) |=> (count_r == 8'h00 && !drive_r))
    else $error("counter moved before first edge");
  chk_edge_polar: assert property (@(posedge pclk) disable iff (!presetn)
    edge_pulse |-> ((cfg.mode == `ELT_MODE_RISE && trig_in) || (cfg.mode == `ELT_MODE_FALL && !trig_in)))
    else $error("edge of wrong polarity qualified");

  cov_one_shot: cover property (@(posedge pclk) disable iff (!presetn) en_clear);
  cov_retrigger: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ELT_RUN && edge_pulse);
  cov_fall_mode: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.mode == `ELT_MODE_FALL && edge_pulse);
endmodule // elt_oneshot_timer

`default_nettype wire

// ==== elt_pkg.sv ====
/*
  Types shared by the one-shot timer modules.
  Assumes elt_regs.svh sits in the same folder.
*/
`include "elt_regs.svh"

package elt_pkg;
  // =====================================================================
  // Timer state and configuration carrier
  // =====================================================================
  typedef enum logic [1:0] {
    ELT_IDLE  = 2'b00,
    ELT_ARMED = 2'b01,
    ELT_HOLD  = 2'b10,
    ELT_RUN   = 2'b11
  } elt_state_t;

  typedef struct packed {
    logic       en;
    logic [4:0] mode;
    logic [7:0] period_value;
    logic [7:0] pulse_width_value;
  } elt_cfg_t;
endpackage

// ==== elt_regs.svh ====
/*
  Register map, field positions, reset values and timing counts of the
  edge-triggered limit one-shot timer.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ELT_REGS_SVH
`define ELT_REGS_SVH

// =====================================================================
// Register byte offsets
// =====================================================================
`define ELT_CTRL_OFS       12'h000
`define ELT_PERIOD_OFS     12'h004
`define ELT_WIDTH_OFS      12'h008
`define ELT_COUNT_OFS      12'h00C
`define ELT_STATUS_OFS     12'h010

// =====================================================================
// Control fields
// =====================================================================
`define ELT_CTRL_EN_BIT    0
`define ELT_CTRL_MODE_LSB  8
`define ELT_CTRL_MODE_MSB  12

// =====================================================================
// Mode codes and reset values
// =====================================================================
`define ELT_MODE_RISE      5'h0C
`define ELT_MODE_FALL      5'h0D
`define ELT_MODE_RST       5'h0C
`define ELT_PERIOD_RST     8'hFF
`define ELT_WIDTH_RST      8'h80

// =====================================================================
// Timing: idle clocks between a reset edge and resumed counting
// =====================================================================
`define ELT_RESUME_CLKS    2'h2

`endif

// ==== elt_trig_src.sv ====
/*
  External trigger source that sits in front of the one-shot timer.
  Assumes the bench requests a pulse with go and sets the polarity first.
*/
`timescale 1ns/1ps
`default_nettype none

module elt_trig_src (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the bench
  input  wire logic       go,
  input  wire logic       fall,
  input  wire logic [2:0] len,
  // Trigger line, synchronous to pclk
  output logic            trig_in
);
  // =====================================================================
  // Pulse timer
  // =====================================================================
  logic [2:0] left_r;

  // Active level lasts len cycles; the trailing edge has the wrong polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 3'h0;
    end else if (go) begin
      left_r <= len;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end
  end

  // Idle level follows polarity so the leading edge is the qualifying one
  assign trig_in = fall ^ (left_r != 3'h0);
endmodule // elt_trig_src

`default_nettype wire

// ==== test_edge_triggered_limit_oneshot_timer.sv ====
/*
  Self-checking bench for the edge-triggered limit one-shot timer.
  Assumes zero-wait APB and a trigger synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "elt_regs.svh"

module test_edge_triggered_limit_oneshot_timer;
  import elt_pkg::*;
  // =====================================================================
  // Signals
  // =====================================================================
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        trig_in, pwm_drive, running, go, fall, e;
  logic [2:0]  len;
  logic [4:0]  md;
  int          errors, tests_run, cyc, per, wd, k;

  elt_oneshot_timer i_elt_oneshot_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .pwm_drive(pwm_drive), .running(running));
  elt_trig_src i_elt_trig_src (.pclk(pclk), .presetn(presetn), .go(go), .fall(fall), .len(len),
    .trig_in(trig_in));

  // =====================================================================
  // Clock and hang guard
  // =====================================================================
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Whole run is under a thousand cycles; cut off well beyond that
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  // =====================================================================
  // Tasks
  // =====================================================================
  task summarize;
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready sampled high or the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask

  // Ask the source for one pulse; returns at the edge that sees it
  task fire;
    @(posedge pclk);
    go  <= 1'b1;
    len <= 3'($urandom_range(1, 4));
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask

  // Per-cycle expectation after an edge: running for n cycles, drive for the first nd-1
  task watch(input int n, input int nd, input logic run);
    for (int i = 1; i <= n; i++) begin
      @(posedge pclk);
      #1;
      chk("running", {31'h0, running}, {31'h0, run});
      chk("pwm_drive", {31'h0, pwm_drive}, {31'h0, run && i < nd});
    end
  endtask

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; go = 1'b0; fall = 1'b0; len = 3'h1;
    void'($urandom(19));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only count and an unmapped place
    rd(`ELT_CTRL_OFS, 32'h00000C00, 1'b0);
    rd(`ELT_PERIOD_OFS, 32'h000000FF, 1'b0);
    rd(`ELT_WIDTH_OFS, 32'h00000080, 1'b0);
    apb(1'b1, `ELT_COUNT_OFS, 32'h00000055);
    rd(`ELT_COUNT_OFS, 32'h0, 1'b0);
    rd(12'h014, 32'h0, 1'b1);
    for (int it = 0; it < 4; it++) begin
      md   = it[0] ? `ELT_MODE_FALL : `ELT_MODE_RISE;
      fall <= md[0];
      per  = $urandom_range(10, 60);
      wd   = (it == 0) ? per : (it == 1) ? 1 : $urandom_range(1, per - 1);
      apb(1'b1, `ELT_PERIOD_OFS, 32'(per));
      apb(1'b1, `ELT_WIDTH_OFS, 32'(wd));
      apb(1'b1, `ELT_CTRL_OFS, {19'h0, md, 8'h00});
      fire();
      watch(4, 0, 1'b0);
      apb(1'b1, `ELT_CTRL_OFS, {19'h0, md, 8'h01});
      repeat (3) @(posedge pclk);
      chk("running", {31'h0, running}, 32'h0);
      fire();
      // Reset edge must land no later than the period-match cycle
      k = $urandom_range(6, per - 3);
      watch(k, wd, 1'b1);
      fire();
      watch(per + 1, ((wd < per) ? wd : per) + 2, 1'b1);
      watch(3, 0, 1'b0);
      rd(`ELT_CTRL_OFS, {19'h0, md, 8'h00}, 1'b0);
      rd(`ELT_COUNT_OFS, 32'h0, 1'b0);
      fire();
      watch(4, 0, 1'b0);
    end
    summarize();
  end
endmodule // test_edge_triggered_limit_oneshot_timer

`default_nettype wire
